/* common/sie_pkg.sv */
// Shared constants for the SPI interrupt status and enable block.
package sie_pkg;
   localparam int unsigned    SIE_ADDR_W          = 7;
   localparam logic [6:0]     SIE_OFS_EVENT_FLAGS = 7'h20;
   localparam logic [6:0]     SIE_OFS_SRC_ENABLES = 7'h28;
   localparam int unsigned    SIE_NUM_BITS        = 14;
   localparam logic [13:0]    SIE_ENABLE_RESET    = 14'h0000;
   localparam logic [13:0]    SIE_FLAGS_RESET     = 14'h0000;
   localparam int unsigned    SIE_BIT_MMODF       = 0;
   localparam int unsigned    SIE_BIT_TMODF       = 1;
   localparam int unsigned    SIE_BIT_TSEL        = 7;
   localparam int unsigned    SIE_BIT_RNE         = 8;
   localparam int unsigned    SIE_BIT_DQ_LO       = 9;
   localparam int unsigned    SIE_BIT_DQ_HI       = 13;
   localparam int unsigned    SIE_RNE_FIFO_DEPTH  = 1;
   localparam logic [17:0]    SIE_RSVD_ZERO       = 18'h0_0000;

   typedef enum logic [1:0] {
      SIE_MODE_STD,
      SIE_MODE_DUAL,
      SIE_MODE_QUAD
   } sie_mode_t;
endpackage

/* common/sie_evt_if.sv */
// Carries per-bit event strobes, toggle strobes and flag values between the register block and the flag bank.
`timescale 1ns/1ps
interface sie_evt_if;
   import sie_pkg::*;
   logic [SIE_NUM_BITS-1:0] set_ev;
   logic [SIE_NUM_BITS-1:0] tog;
   logic [SIE_NUM_BITS-1:0] flags;

   modport ctrl (output set_ev, output tog, input flags);
   modport bank (input set_ev, input tog, output flags);
endinterface

/* hdl/sie_flag_bank.sv */
// Bank of sticky event flags with toggle-on-write access.
`timescale 1ns/1ps
module sie_flag_bank
   import sie_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   sie_evt_if.bank   evt
);
   logic [SIE_NUM_BITS-1:0] flags_q;
   logic [SIE_NUM_BITS-1:0] flags_d;

   // A hardware set wins over a toggle that would clear the flag in the same cycle.
   genvar g;
   generate
      for (g = 0; g < SIE_NUM_BITS; g++) begin : g_bit
         always_comb begin
            if (evt.set_ev[g]) begin
               flags_d[g] = 1'b1;
            end else begin
               flags_d[g] = flags_q[g] ^ evt.tog[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flags_q <= SIE_FLAGS_RESET;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign evt.flags = flags_q;
endmodule

/* hdl/sie_spi_irq.sv */
// Interrupt status and enable registers of a SPI controller core.
`timescale 1ns/1ps
module sie_spi_irq
   import sie_pkg::*;
#(
   parameter sie_mode_t   SPI_MODE   = SIE_MODE_STD,
   parameter int unsigned FIFO_DEPTH = 16
)(
   input  wire logic                    clk_i,
   input  wire logic                    rst_b_i,
   input  wire logic                    reg_wr_i,
   input  wire logic                    reg_rd_i,
   input  wire logic [SIE_ADDR_W-1:0]   reg_addr_i,
   input  wire logic [31:0]             reg_wdata_i,
   output logic      [31:0]             reg_rdata_o,
   input  wire logic                    master_i,
   input  wire logic                    core_en_i,
   input  wire logic                    sel_active_i,
   input  wire logic [SIE_NUM_BITS-1:0] event_i,
   output logic                         irq_o
);
   sie_evt_if evt ();

   logic [SIE_NUM_BITS-1:0] en_q;
   logic [SIE_NUM_BITS-1:0] en_d;
   logic [31:0]             rdata_q;
   logic [31:0]             rdata_d;
   logic                    sel_q;
   logic                    sel_d;
   logic [SIE_NUM_BITS-1:0] eff_mask;
   logic                    sel_rise;

   // Only the FIFO depths that the core can be built with are accepted.
   generate
      if (FIFO_DEPTH != 0 && FIFO_DEPTH != SIE_RNE_FIFO_DEPTH && FIFO_DEPTH != 16 && FIFO_DEPTH != 256) begin : g_bad_depth
         $error("FIFO_DEPTH must be 0, 1, 16 or 256");
      end
   endgenerate

   sie_flag_bank u_bank (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .evt     (evt)
   );

   assign sel_rise = sel_active_i & ~sel_q;

   always_comb begin
      evt.set_ev                = event_i;
      evt.set_ev[SIE_BIT_MMODF] = event_i[SIE_BIT_MMODF] | (sel_rise & master_i);
      evt.set_ev[SIE_BIT_TMODF] = event_i[SIE_BIT_TMODF]
                                | (sel_active_i & ~master_i & ~core_en_i);
   end

   always_comb begin
      evt.tog = '0;
      if (reg_wr_i && reg_addr_i == SIE_OFS_EVENT_FLAGS) begin
         evt.tog = reg_wdata_i[SIE_NUM_BITS-1:0];
      end
   end

   always_comb begin
      en_d = en_q;
      if (reg_wr_i && reg_addr_i == SIE_OFS_SRC_ENABLES) begin
         en_d = reg_wdata_i[SIE_NUM_BITS-1:0];
      end
   end

   always_comb begin
      eff_mask = en_q;
      if (SPI_MODE == SIE_MODE_STD) begin
         eff_mask[SIE_BIT_DQ_HI:SIE_BIT_DQ_LO] = '0;
      end
      if (!(SPI_MODE == SIE_MODE_STD && FIFO_DEPTH == SIE_RNE_FIFO_DEPTH && !master_i)) begin
         eff_mask[SIE_BIT_RNE] = 1'b0;
      end
      if (master_i) begin
         eff_mask[SIE_BIT_TSEL] = 1'b0;
      end
   end

   always_comb begin
      sel_d = sel_active_i;
   end

   always_comb begin
      rdata_d = '0;
      if (reg_rd_i) begin
         case (reg_addr_i)
            SIE_OFS_EVENT_FLAGS: rdata_d = {SIE_RSVD_ZERO, evt.flags};
            SIE_OFS_SRC_ENABLES: rdata_d = {SIE_RSVD_ZERO, en_q};
            default:             rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         en_q <= SIE_ENABLE_RESET;
      end else begin
         en_q <= en_d;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // The select tracker resets to the idle level, so a select already active when reset ends is taken as a rise.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sel_q <= 1'b0;
      end else begin
         sel_q <= sel_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   // Software is expected to poll bit 2 for end of transfer; it is an ordinary flag here.
   assign irq_o = |(evt.flags & eff_mask);
endmodule

/* testbench/sie_spi_irq_monitor.sv */
// Port checker for the SPI interrupt status and enable block.
`timescale 1ns/1ps
module sie_spi_irq_monitor
   import sie_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [6:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic [31:0] reg_rdata_o,
   input  wire logic        master_i,
   input  wire logic        core_en_i,
   input  wire logic        sel_active_i,
   input  wire logic [13:0] event_i,
   input  wire logic        irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence wen_s; reg_wr_i && reg_addr_i == SIE_OFS_SRC_ENABLES; endsequence
   sequence ren_s; reg_rd_i && reg_addr_i == SIE_OFS_SRC_ENABLES; endsequence
   rsvd_zero_a: assert property (reg_rdata_o[31:14] == 0) else $error("rsvd");
   rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 0) else $error("idle");
   unmapped_zero_a: assert property ($past(reg_rd_i && reg_addr_i != SIE_OFS_EVENT_FLAGS
      && reg_addr_i != SIE_OFS_SRC_ENABLES) |-> reg_rdata_o == 0) else $error("unmapped");
   enable_readback_a: assert property (wen_s ##1 !reg_wr_i ##1 ren_s
      |=> reg_rdata_o == {18'h0, $past(reg_wdata_i[13:0], 3)}) else $error("readback");
   enable_off_a: assert property (wen_s and reg_wdata_i[13:0] == 0 |=> !irq_o) else $error("off");
   fault_irq_a: assert property ((wen_s and reg_wdata_i[0]) ##1 (master_i && $rose(sel_active_i) && !reg_wr_i)
      |=> irq_o) else $error("fault");
   irq_rise_a: assert property ($rose(irq_o) |-> $past(reg_wr_i || sel_active_i || |event_i)
      || !$stable(master_i)) else $error("rise");
   irq_hold_a: assert property ($fell(irq_o) |-> $past(reg_wr_i) || !$stable(master_i)) else $error("hold");
endmodule
bind sie_spi_irq sie_spi_irq_monitor u_mon (.*);

/* testbench/sie_spi_irq_tb.sv */
// Self-checking bench for the SPI interrupt status and enable block.
`timescale 1ns/1ps
module sie_spi_irq_tb;
   import sie_pkg::*;
   logic clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, master_i = 0, core_en_i = 0, sel_active_i = 0;
   logic [6:0] reg_addr_i = 0;
   logic [31:0] reg_wdata_i = 0, reg_rdata_o;
   logic [13:0] event_i = 0;
   logic irq_o;
   logic irq_s1;
   logic irq_dq;
   int bad_count = 0, compares = 0;
   initial forever #4 clk_i = ~clk_i;
   sie_spi_irq DUT (.*);
   // Two more builds share the stimulus: a depth-one standard core and a dual-mode core.
   sie_spi_irq #(.SPI_MODE(SIE_MODE_STD), .FIFO_DEPTH(1)) DUT_S1 (
      .clk_i        (clk_i),
      .rst_b_i      (rst_b_i),
      .reg_wr_i     (reg_wr_i),
      .reg_rd_i     (reg_rd_i),
      .reg_addr_i   (reg_addr_i),
      .reg_wdata_i  (reg_wdata_i),
      .reg_rdata_o  (),
      .master_i     (master_i),
      .core_en_i    (core_en_i),
      .sel_active_i (sel_active_i),
      .event_i      (event_i),
      .irq_o        (irq_s1)
   );
   sie_spi_irq #(.SPI_MODE(SIE_MODE_DUAL), .FIFO_DEPTH(16)) DUT_DQ (
      .clk_i        (clk_i),
      .rst_b_i      (rst_b_i),
      .reg_wr_i     (reg_wr_i),
      .reg_rd_i     (reg_rd_i),
      .reg_addr_i   (reg_addr_i),
      .reg_wdata_i  (reg_wdata_i),
      .reg_rdata_o  (),
      .master_i     (master_i),
      .core_en_i    (core_en_i),
      .sel_active_i (sel_active_i),
      .event_i      (event_i),
      .irq_o        (irq_dq)
   );
   task chk(input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %0t seen %h want %h", $time, s, e);
      end
   endtask
   task acc(input logic w, input logic [6:0] a, input logic [31:0] d);
      @(negedge clk_i); reg_wr_i = w; reg_rd_i = !w; reg_addr_i = a; reg_wdata_i = d;
      @(negedge clk_i); reg_wr_i = 0; reg_rd_i = 0;
   endtask
   task rd(input logic [6:0] a, input logic [31:0] e); acc(0, a, 0); chk(reg_rdata_o, e); endtask
   task t_reset; rd(7'h20, 0); rd(7'h28, 0); rd(7'h24, 0); endtask
   task t_fault;
      acc(1, 7'h28, 32'hFFFF_FFFF); rd(7'h28, 32'h0000_3FFF); acc(1, 7'h28, 1);
      master_i = 1; sel_active_i = 1; @(negedge clk_i); chk(irq_o, 1);
      sel_active_i = 0; rd(7'h20, 1); chk(irq_o, 1);
      acc(1, 7'h20, 1); chk(irq_o, 0); rd(7'h20, 0);
      acc(1, 7'h20, 2); rd(7'h20, 2); acc(1, 7'h20, 2);
   endtask
   // Master, standard mode and deep FIFO together mask every source from bit 13 down to bit 7.
   task t_mask;
      acc(1, 7'h28, 32'h0000_3F80); event_i = 14'h3F80; @(negedge clk_i); event_i = 0;
      @(negedge clk_i); chk(irq_o, 0);
      chk(irq_s1, 0); chk(irq_dq, 1);
      master_i = 0; #1 chk(irq_o, 1);
      chk(irq_s1, 1);
      acc(1, 7'h28, 32'h0000_3E00); chk(irq_o, 0); chk(irq_dq, 1);
      acc(1, 7'h28, 32'h0000_0100); chk(irq_o, 0); chk(irq_s1, 1); chk(irq_dq, 0);
      acc(1, 7'h28, 0); chk(irq_o, 0);
   endtask
   // A toggle while the fault condition persists must not clear the flag.
   task t_slave;
      acc(1, 7'h28, 2); sel_active_i = 1; acc(1, 7'h20, 2); chk(irq_o, 1);
      sel_active_i = 0; acc(1, 7'h20, 2); chk(irq_o, 0);
      core_en_i = 1; sel_active_i = 1; rd(7'h20, 32'h0000_3F80); chk(irq_o, 0);
      sel_active_i = 0; core_en_i = 0; event_i = 14'h0004; @(negedge clk_i); event_i = 0;
      rd(7'h20, 32'h0000_3F84);
   endtask
   task finish_test;
      $display("bad_count=%0d compares=%0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge clk_i);
      rst_b_i = 1;
      t_reset; t_fault; t_mask; t_slave;
      finish_test;
   end
   initial begin
      #20000;
      bad_count++;
      finish_test;
   end
endmodule
